// >>> src/smc_standby_ctrl.sv
// How it works
// - halt stops cpu; oscillators, base timer, peripherals keep entry state.
// - full stop wakes only on external a-c, e, port 0, or reset.
// - subclock stop keeps subclock and base timer; base timer also wakes.
// - leaving halt clears the halt flag, bit zero.
// - leaving either stop clears stop bit one, halt flag stays set.
// - interrupt wake: halt to normal, stops to halt; reset goes normal.
// - setting the stop request bit also sets the halt flag.
// - halt flag clears on wake or accepted interrupt in halt, or on reset.
// - halt flag alone gives halt; stop bit gives stop, bit two selects variant.
`timescale 1ns/100ps
module smc_standby_ctrl
   import smc_pkg::*;
(
   input  wire logic              mclk_i,
   input  wire logic              reset_n_i,
   input  wire logic              power_control_reg_we_i,
   input  wire logic [POWER_CONTROL_REG_W-1:0] power_control_reg_wdata_i,
   input  wire logic [WAKE_W-1:0] irq_i,
   input  wire logic              irq_accept_i,
   input  wire smc_run_s          run_i,
   output logic [POWER_CONTROL_REG_W-1:0]      power_control_reg_o,
   output smc_mode_e              mode_o,
   output smc_gate_s              gate_o
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic              wake;
   smc_mode_e         mode_r;
   smc_mode_e         mode_nxt;
   logic [POWER_CONTROL_REG_W-1:0] power_control_reg_r;
   logic [POWER_CONTROL_REG_W-1:0] power_control_reg_nxt;
   smc_gate_s         gate_r;
   smc_gate_s         gate_nxt;
   smc_run_s          held_r;
   smc_run_s          held_nxt;

   // ----------------------------------------
   // wake decode
   // ----------------------------------------
   smc_wake_decode i_smc_wake_decode (
      .mclk_i    (mclk_i),
      .reset_n_i (reset_n_i),
      .mode_i    (mode_r),
      .irq_i     (irq_i),
      .wake_o    (wake)
   );

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic smc_gate_s gate_from_run(input logic cpu_on, input smc_run_s src);
      smc_gate_s g;
      g.cpu_run     = cpu_on;
      g.main_osc_en = src.main_osc;
      g.low_rc_en   = src.low_rc;
      g.med_rc_en   = src.med_rc;
      g.multi_rc_en = src.multi_rc;
      g.sub_osc_en  = src.sub_osc;
      g.btimer_en   = src.btimer;
      g.periph_en   = src.periph;
      return g;
   endfunction

   // ----------------------------------------
   // power control register and mode
   // ----------------------------------------
   always_comb begin
      power_control_reg_nxt = power_control_reg_r;
      mode_nxt = mode_r;
      held_nxt = held_r;
      unique case (mode_r)
         SMC_NORMAL: begin
            if (power_control_reg_we_i) begin
               power_control_reg_nxt = power_control_reg_wdata_i;
               if (power_control_reg_wdata_i[STOP_BIT]) begin
                  power_control_reg_nxt[HALT_BIT] = 1'b1;
                  mode_nxt = power_control_reg_wdata_i[SUBSEL_BIT] ? SMC_SUBSTOP : SMC_STOP;
               end else if (power_control_reg_wdata_i[HALT_BIT]) begin
                  mode_nxt = SMC_HALT;
               end
               held_nxt = run_i;
            end
         end
         SMC_HALT: begin
            if (wake || irq_accept_i) begin
               power_control_reg_nxt[HALT_BIT] = 1'b0;
               mode_nxt = SMC_NORMAL;
            end
         end
         SMC_STOP, SMC_SUBSTOP: begin
            if (wake) begin
               power_control_reg_nxt[STOP_BIT] = 1'b0;
               mode_nxt = SMC_HALT;
            end
         end
      endcase
   end

   // ----------------------------------------
   // clock and block gating
   // ----------------------------------------
   always_comb begin
      gate_nxt = GATE_RESET;
      unique case (mode_nxt)
         SMC_NORMAL: gate_nxt = gate_from_run(1'b1, run_i);
         SMC_HALT: begin
            gate_nxt = gate_from_run(1'b0, held_nxt);
         end
         SMC_STOP: gate_nxt = '0;
         SMC_SUBSTOP: begin
            gate_nxt = '0;
            gate_nxt.sub_osc_en = held_nxt.sub_osc;
            gate_nxt.btimer_en  = held_nxt.btimer;
         end
      endcase
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         power_control_reg_r <= POWER_CONTROL_REG_RESET;
         mode_r <= SMC_NORMAL;
         held_r <= '0;
      end else begin
         power_control_reg_r <= power_control_reg_nxt;
         mode_r <= mode_nxt;
         held_r <= held_nxt;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         gate_r <= GATE_RESET;
      end else begin
         gate_r <= gate_nxt;
      end
   end

   assign power_control_reg_o = power_control_reg_r;
   assign mode_o              = mode_r;
   assign gate_o              = gate_r;

   // ----------------------------------------
   // mode checks
   // ----------------------------------------
   a_halt_exit_clear: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (mode_r == SMC_HALT && wake) |=> (mode_r == SMC_NORMAL && !power_control_reg_r[HALT_BIT]))
      else $error("halt exit wrong");

   a_halt_accept_exit: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (mode_r == SMC_HALT && irq_accept_i) |=>
      (mode_r == SMC_NORMAL && !power_control_reg_r[HALT_BIT]))
      else $error("accepted interrupt did not end halt");

   a_stop_exit_halt: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      ((mode_r == SMC_STOP || mode_r == SMC_SUBSTOP) && wake) |=>
      (mode_r == SMC_HALT && !power_control_reg_r[STOP_BIT] && power_control_reg_r[HALT_BIT]))
      else $error("stop exit wrong");

   a_stop_ext_wake: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (mode_r == SMC_STOP && (irq_i & STOP_WAKE_MASK) != '0) |=>
      (mode_r == SMC_HALT))
      else $error("full stop missed a wake source");

   a_stop_no_exit: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      ((mode_r == SMC_STOP && (irq_i & STOP_WAKE_MASK) == '0)
       || (mode_r == SMC_SUBSTOP && (irq_i & SUB_WAKE_MASK) == '0)) |=>
      ($stable(mode_r) && $stable(power_control_reg_r)))
      else $error("stop left without wake");

   a_sub_btimer_wake: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (mode_r == SMC_SUBSTOP && irq_i[WK_BTIMER]) |=>
      (mode_r == SMC_HALT && !power_control_reg_r[STOP_BIT]))
      else $error("base timer did not end subclock stop");

   a_stop_sets_halt: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (mode_r == SMC_NORMAL && power_control_reg_we_i && power_control_reg_wdata_i[STOP_BIT]) |=>
      (power_control_reg_r[HALT_BIT] && mode_r != SMC_NORMAL))
      else $error("stop did not set halt");

   a_sub_select: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (mode_r == SMC_NORMAL && power_control_reg_we_i && power_control_reg_wdata_i[STOP_BIT]) |=>
      (mode_r == ($past(power_control_reg_wdata_i[SUBSEL_BIT]) ? SMC_SUBSTOP : SMC_STOP)))
      else $error("stop variant wrong");

   a_halt_entry: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (mode_r == SMC_NORMAL && power_control_reg_we_i && !power_control_reg_wdata_i[STOP_BIT] && power_control_reg_wdata_i[HALT_BIT])
      |=> mode_r == SMC_HALT)
      else $error("halt not entered");

   // ----------------------------------------
   // gating checks
   // ----------------------------------------
   a_halt_cpu_off: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      mode_r == SMC_HALT |-> (!gate_r.cpu_run && gate_r.btimer_en == held_r.btimer
                              && gate_r.periph_en == held_r.periph))
      else $error("halt gating wrong");

   a_halt_hold: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (mode_r == SMC_HALT && irq_i == '0 && !irq_accept_i) |=>
      (mode_r == SMC_HALT && $stable(gate_r)))
      else $error("halt gating drifted");

   a_halt_entry_gate: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (mode_r == SMC_NORMAL && power_control_reg_we_i && power_control_reg_wdata_i[HALT_BIT] && !power_control_reg_wdata_i[STOP_BIT])
      |=> (gate_r == {1'b0, $past(run_i)}))
      else $error("halt did not keep entry gating");

   a_normal_gate: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (mode_r == SMC_HALT && irq_accept_i) |=> (gate_r == {1'b1, $past(run_i)}))
      else $error("normal gating wrong after halt");

   a_stop_all_off: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      mode_r == SMC_STOP |-> gate_r == '0)
      else $error("full stop gating wrong");

   a_substop_keep: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      mode_r == SMC_SUBSTOP |-> (!gate_r.cpu_run && gate_r.btimer_en == held_r.btimer
                                 && !gate_r.main_osc_en && !gate_r.periph_en))
      else $error("subclock stop gating wrong");

   // ----------------------------------------
   // reset check
   // ----------------------------------------
   a_reset_normal: assert property (@(posedge mclk_i)
      !reset_n_i |=> (mode_r == SMC_NORMAL && power_control_reg_r == POWER_CONTROL_REG_RESET))
      else $error("reset state wrong");
endmodule

// >>> shared/smc_pkg.sv
package smc_pkg;

   // ----------------------------------------
   // power-control register layout
   // ----------------------------------------
   localparam int          POWER_CONTROL_REG_W          = 3;
   localparam int          HALT_BIT        = 0;
   localparam int          STOP_BIT        = 1;
   localparam int          SUBSEL_BIT      = 2;
   localparam logic [2:0]  POWER_CONTROL_REG_RESET      = 3'h0;

   // ----------------------------------------
   // wake source vector layout
   // ----------------------------------------
   localparam int          WAKE_W          = 6;
   localparam int          WK_EXT_A        = 0;
   localparam int          WK_EXT_B        = 1;
   localparam int          WK_EXT_C        = 2;
   localparam int          WK_EXT_E        = 3;
   localparam int          WK_PORT0        = 4;
   localparam int          WK_BTIMER       = 5;
   localparam logic [5:0]  STOP_WAKE_MASK  = 6'h1F;
   localparam logic [5:0]  SUB_WAKE_MASK   = 6'h3F;

   typedef enum logic [1:0] {
      SMC_NORMAL,
      SMC_HALT,
      SMC_STOP,
      SMC_SUBSTOP
   } smc_mode_e;

   typedef struct packed {
      logic cpu_run;
      logic main_osc_en;
      logic low_rc_en;
      logic med_rc_en;
      logic multi_rc_en;
      logic sub_osc_en;
      logic btimer_en;
      logic periph_en;
   } smc_gate_s;

   typedef struct packed {
      logic main_osc;
      logic low_rc;
      logic med_rc;
      logic multi_rc;
      logic sub_osc;
      logic btimer;
      logic periph;
   } smc_run_s;

   localparam smc_gate_s GATE_RESET = '{cpu_run: 1'b1, default: 1'b0};

endpackage

// >>> src/smc_wake_decode.sv
`timescale 1ns/100ps
module smc_wake_decode
   import smc_pkg::*;
(
   input  wire logic              mclk_i,
   input  wire logic              reset_n_i,
   input  wire smc_mode_e         mode_i,
   input  wire logic [WAKE_W-1:0] irq_i,
   output logic                   wake_o
);
   // ----------------------------------------
   // qualify wake sources by mode
   // ----------------------------------------
   logic [WAKE_W-1:0] mask;

   always_comb begin
      unique case (mode_i)
         SMC_NORMAL:  mask = '0;
         SMC_HALT:    mask = SUB_WAKE_MASK;
         SMC_STOP:    mask = STOP_WAKE_MASK;
         SMC_SUBSTOP: mask = SUB_WAKE_MASK;
      endcase
   end

   assign wake_o = |(irq_i & mask);

   a_stop_no_btimer: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (mode_i == SMC_STOP && irq_i == (WAKE_W'(1) << WK_BTIMER)) |-> !wake_o)
      else $error("base timer woke full stop");
endmodule

// >>> verif/smc_standby_ctrl_tb.sv
`timescale 1ns/100ps
module smc_standby_ctrl_tb
   import smc_pkg::*;
();
   logic              mclk = 1'b0;
   logic              rst_n = 1'b0;
   logic              we = 1'b0;
   logic [POWER_CONTROL_REG_W-1:0] wdata = 3'h0;
   logic [WAKE_W-1:0] irq = 6'h00;
   logic              acc = 1'b0;
   smc_run_s          run = 7'h5A;
   logic [POWER_CONTROL_REG_W-1:0] power_control_reg;
   smc_mode_e         mode;
   smc_gate_s         gate;
   int                fail_count = 0;
   int                comparisons = 0;

   smc_standby_ctrl i_smc_standby_ctrl (.mclk_i(mclk), .reset_n_i(rst_n), .power_control_reg_we_i(we),
      .power_control_reg_wdata_i(wdata), .irq_i(irq), .irq_accept_i(acc), .run_i(run),
      .power_control_reg_o(power_control_reg), .mode_o(mode), .gate_o(gate));

   initial begin
      forever #25 mclk = ~mclk;
   end

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic st(input smc_mode_e m, input logic [2:0] p);
      chk("mode", 8'(mode), 8'(m));
      chk("power_control_reg", 8'(power_control_reg), 8'(p));
   endtask
   task automatic wr(input logic [2:0] d);
      @(negedge mclk) we = 1'b1; wdata = d;
      @(negedge mclk) we = 1'b0;
   endtask
   task automatic wake(input logic [5:0] m, input logic a);
      @(negedge mclk) irq = m; acc = a;
      @(negedge mclk) irq = 6'h00; acc = 1'b0;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_halt();
      st(SMC_NORMAL, 3'h0);
      chk("gate", gate, GATE_RESET);
      wake(6'h3F, 1'b0);
      st(SMC_NORMAL, 3'h0);
      wr(3'h1);
      st(SMC_HALT, 3'h1);
      chk("gate", gate, {1'b0, run});
      run = 7'h25;
      wr(3'h2);
      st(SMC_HALT, 3'h1);
      chk("gate", gate, 8'h5A);
      wake(6'h00, 1'b1);
      st(SMC_NORMAL, 3'h0);
      chk("cpu", 8'(gate.cpu_run), 8'h01);
      chk("gate", gate, 8'hA5);
      wr(3'h1);
      st(SMC_HALT, 3'h1);
      wake(6'h10, 1'b0);
      st(SMC_NORMAL, 3'h0);
   endtask
   task automatic t_stop();
      for (int i = 0; i < 5; i++) begin
         wr(3'h2);
         st(SMC_STOP, 3'h3);
         chk("gate", gate, 8'h00);
         wake(6'h01 << WK_BTIMER, 1'b0);
         st(SMC_STOP, 3'h3);
         wake(6'h00, 1'b1);
         st(SMC_STOP, 3'h3);
         wake(6'h01 << i, 1'b0);
         st(SMC_HALT, 3'h1);
         wake(6'h00, 1'b1);
         st(SMC_NORMAL, 3'h0);
      end
   endtask
   task automatic t_sub();
      run = 7'h7F;
      wr(3'h6);
      st(SMC_SUBSTOP, 3'h7);
      chk("gate", gate, 8'h06);
      wake(6'h01 << WK_BTIMER, 1'b0);
      st(SMC_HALT, 3'h5);
      wake(6'h00, 1'b1);
      st(SMC_NORMAL, 3'h4);
   endtask
   task automatic t_rst();
      wr(3'h2);
      @(negedge mclk) rst_n = 1'b0;
      @(negedge mclk) rst_n = 1'b1;
      st(SMC_NORMAL, 3'h0);
   endtask

   // ----------------------------------------
   // run control
   // ----------------------------------------
   task automatic complete_run();
      $display("checks %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (3) @(negedge mclk);
      rst_n = 1'b1;
      t_halt();
      t_stop();
      t_sub();
      t_rst();
      complete_run();
   end

   initial begin
      #(2000 * 50);
      fail_count++;
      complete_run();
   end
endmodule
